// *** include/ddr_sram_consts.svh ***
`ifndef DDR_SRAM_CONSTS_SVH
`define DDR_SRAM_CONSTS_SVH

// ----------------------------------------------------------------
// organisation
// ----------------------------------------------------------------
`define ORG_WIDE_DW 36
`define ORG_WIDE_AW 19
`define ORG_NARROW_DW 18
`define ORG_NARROW_AW 20
`define BYTE_LANE_W 9
`define BEATS_PER_BURST 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_PS 4000
`define DLL_LOCK_TIME_NS 4000
`define DLL_LOCK_CYCLES ((`DLL_LOCK_TIME_NS * 1000 + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS)
`define DLL_LOCK_CNT_W 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SYNC_RESET_VAL 1'b0

`endif

// *** include/ddr_sram_pkg.sv ***
package ddr_sram_pkg;

    // ----------------------------------------------------------------
    // read latency selection
    // ----------------------------------------------------------------
    typedef enum logic {
        LAT_ONE_CYCLE,
        LAT_TWO_CYCLE
    } latency_mode_t;

    // ----------------------------------------------------------------
    // link command decoded at a true clock edge
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_READ,
        CMD_WRITE
    } link_cmd_t;

endpackage : ddr_sram_pkg

// *** hw/bit_sync.sv ***
`include "ddr_sram_consts.svh"

module bit_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // level in and out
    input wire logic d_in,
    output logic q_out
);

    logic meta;

    // the first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= `SYNC_RESET_VAL;
            q_out <= `SYNC_RESET_VAL;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end

endmodule : bit_sync

// *** hw/ddr_sram_port.sv ***
`include "ddr_sram_consts.svh"

// Overview of operation
// - commands sampled on true clock rising only
// - every access is a two beat burst
// - read and write may occupy successive edges
// - write beat one one cycle after command
// - write beat two on following complement edge
// - per-beat byte masks skip bytes independently
// - read beat one two edges after command
// - read beat two on third complement edge
// - echo clock pair aligned to read data
// - shared data bus, device drives reads only
// - pipelined reads, buffered self-timed late writes
// - 1Mx36 or 2Mx18 organisation selectable
// - read valid flag aligned with echo clocks
// - deselected cycles start no access
// - dll bypass gives one cycle latency
module ddr_sram_port #(
    parameter bit WIDE_ORG = 1'b1,
    localparam int DW = WIDE_ORG ? `ORG_WIDE_DW : `ORG_NARROW_DW,
    localparam int AW = WIDE_ORG ? `ORG_WIDE_AW : `ORG_NARROW_AW,
    localparam int NB = DW / `BYTE_LANE_W
) (
    // core clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // link clock, complement assumed exactly inverted
    input wire logic k_clk_in,
    // dll control and status
    input wire logic dll_off_n_in,
    output logic dll_locked_out,
    // command and address
    input wire logic load_select_n_in,
    input wire logic read_not_write_in,
    input wire logic [AW-1:0] sync_address_bus_in,
    // shared data bus and byte masks
    input wire logic [DW-1:0] dq_in,
    output logic [DW-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic [NB-1:0] byte_write_mask_n_in,
    // echo clocks and valid
    output logic echo_clock_true_out,
    output logic echo_clock_complement_out,
    output logic read_valid_flag_out
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    localparam logic [`DLL_LOCK_CNT_W-1:0] LOCK_LAST = `DLL_LOCK_CNT_W'(`DLL_LOCK_CYCLES);

    // bytes whose mask bit is low take the new value
    function automatic logic [DW-1:0] merge_bytes(
        input logic [DW-1:0] old_w,
        input logic [DW-1:0] new_w,
        input logic [NB-1:0] skip_n
    );
        logic [DW-1:0] res;
        res = old_w;
        for (int b = 0; b < NB; b++) begin
            if (!skip_n[b]) begin
                res[b*`BYTE_LANE_W +: `BYTE_LANE_W] = new_w[b*`BYTE_LANE_W +: `BYTE_LANE_W];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic [AW:0] beat_index(input logic [AW-1:0] addr, input logic beat);
        return {addr, beat};
    endfunction : beat_index

    // ----------------------------------------------------------------
    // core domain: dll bypass and lock tracking
    // ----------------------------------------------------------------
    logic dll_on_core;
    logic dll_bypass_core;
    logic [`DLL_LOCK_CNT_W-1:0] lock_cnt;

    bit_sync u_doff_sync (
        .clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .d_in(dll_off_n_in),
        .q_out(dll_on_core)
    );

    // holding the input low also clears the lock history
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_cnt <= '0;
        end else if (!dll_on_core) begin
            lock_cnt <= '0;
        end else if (lock_cnt != LOCK_LAST) begin
            lock_cnt <= lock_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dll_locked_out <= 1'b0;
            dll_bypass_core <= 1'b1;
        end else begin
            dll_locked_out <= dll_on_core && (lock_cnt == LOCK_LAST);
            dll_bypass_core <= !dll_on_core;
        end
    end

    // ----------------------------------------------------------------
    // link domain reset and mode crossing
    // ----------------------------------------------------------------
    logic rst_k_n;
    logic bypass_k;
    ddr_sram_pkg::latency_mode_t lat_mode;

    // asynchronous assert, release aligned to the link clock
    bit_sync u_rst_sync (
        .clk_in(k_clk_in),
        .rstn_in(rstn_in),
        .d_in(1'b1),
        .q_out(rst_k_n)
    );

    bit_sync u_bypass_sync (
        .clk_in(k_clk_in),
        .rstn_in(rstn_in),
        .d_in(dll_bypass_core),
        .q_out(bypass_k)
    );

    // switching mode with reads in flight may drop or repeat a burst
    assign lat_mode = bypass_k ? ddr_sram_pkg::LAT_ONE_CYCLE : ddr_sram_pkg::LAT_TWO_CYCLE;

    // ----------------------------------------------------------------
    // command decode at the true clock rising edge
    // ----------------------------------------------------------------
    ddr_sram_pkg::link_cmd_t cmd;

    always_comb begin
        if (load_select_n_in) begin
            cmd = ddr_sram_pkg::CMD_IDLE;
        end else if (read_not_write_in) begin
            cmd = ddr_sram_pkg::CMD_READ;
        end else begin
            cmd = ddr_sram_pkg::CMD_WRITE;
        end
    end

    // ----------------------------------------------------------------
    // storage, two beats per burst address
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [0:(2**(AW+1))-1];

    // ----------------------------------------------------------------
    // late write buffer
    // ----------------------------------------------------------------
    logic wr_cmd_d;
    logic [AW-1:0] wr_addr_d;
    logic wb_vld;
    logic [AW-1:0] wb_addr;
    logic [DW-1:0] wb_d0;
    logic [DW-1:0] wb_d1;
    logic [NB-1:0] wb_m0;
    logic [NB-1:0] wb_m1;

    // address and command only on the true edge
    always_ff @(posedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            wr_cmd_d <= 1'b0;
            wr_addr_d <= '0;
        end else begin
            wr_cmd_d <= (cmd == ddr_sram_pkg::CMD_WRITE);
            if (cmd == ddr_sram_pkg::CMD_WRITE) begin
                wr_addr_d <= sync_address_bus_in;
            end
        end
    end

    // first beat and its masks one cycle after the command
    always_ff @(posedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            wb_vld <= 1'b0;
            wb_addr <= '0;
            wb_d0 <= '0;
            wb_m0 <= '1;
        end else begin
            wb_vld <= wr_cmd_d;
            if (wr_cmd_d) begin
                wb_addr <= wr_addr_d;
                wb_d0 <= dq_in;
                wb_m0 <= byte_write_mask_n_in;
            end
        end
    end

    // second beat on the complement edge right after the first
    always_ff @(negedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            wb_d1 <= '0;
            wb_m1 <= '1;
        end else if (wb_vld) begin
            wb_d1 <= dq_in;
            wb_m1 <= byte_write_mask_n_in;
        end
    end

    // commit once both beats are held; masked bytes keep old contents
    always_ff @(posedge k_clk_in) begin
        if (rst_k_n && wb_vld) begin
            mem[beat_index(wb_addr, 1'b0)] <= merge_bytes(mem[beat_index(wb_addr, 1'b0)],
                wb_d0, wb_m0);
            mem[beat_index(wb_addr, 1'b1)] <= merge_bytes(mem[beat_index(wb_addr, 1'b1)],
                wb_d1, wb_m1);
        end
    end

    // ----------------------------------------------------------------
    // read pipeline
    // ----------------------------------------------------------------
    logic rd_v1;
    logic rd_v2;
    logic [AW-1:0] rd_a1;
    logic [AW-1:0] rd_a2;
    logic rd_go;
    logic [AW-1:0] rd_addr;
    logic wb_hit;
    logic [DW-1:0] next_beat0;
    logic [DW-1:0] next_beat1;

    always_ff @(posedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            rd_v1 <= 1'b0;
            rd_v2 <= 1'b0;
            rd_a1 <= '0;
            rd_a2 <= '0;
        end else begin
            rd_v1 <= (cmd == ddr_sram_pkg::CMD_READ);
            if (cmd == ddr_sram_pkg::CMD_READ) begin
                rd_a1 <= sync_address_bus_in;
            end
            rd_v2 <= rd_v1;
            rd_a2 <= rd_a1;
        end
    end

    always_comb begin
        case (lat_mode)
            ddr_sram_pkg::LAT_ONE_CYCLE: begin
                rd_go = rd_v1;
                rd_addr = rd_a1;
            end
            ddr_sram_pkg::LAT_TWO_CYCLE: begin
                rd_go = rd_v2;
                rd_addr = rd_a2;
            end
            default: begin
                rd_go = 1'b0;
                rd_addr = '0;
            end
        endcase
    end

    // a write still in the buffer overrides the array contents
    assign wb_hit = wb_vld && (wb_addr == rd_addr);

    always_comb begin
        next_beat0 = mem[beat_index(rd_addr, 1'b0)];
        next_beat1 = mem[beat_index(rd_addr, 1'b1)];
        if (wb_hit) begin
            next_beat0 = merge_bytes(next_beat0, wb_d0, wb_m0);
            next_beat1 = merge_bytes(next_beat1, wb_d1, wb_m1);
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    logic rd_active;
    logic [DW-1:0] q_beat0;
    logic [DW-1:0] q_beat1_hold;
    logic [DW-1:0] q_beat1;

    always_ff @(posedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            rd_active <= 1'b0;
            q_beat0 <= '0;
            q_beat1_hold <= '0;
        end else begin
            rd_active <= rd_go;
            if (rd_go) begin
                q_beat0 <= next_beat0;
                q_beat1_hold <= next_beat1;
            end
        end
    end

    always_ff @(negedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            q_beat1 <= '0;
        end else begin
            q_beat1 <= q_beat1_hold;
        end
    end

    // ----------------------------------------------------------------
    // echo clocks from the same two edges as the data
    // ----------------------------------------------------------------
    logic tgl_rise;
    logic tgl_fall;
    logic echo_phase;

    always_ff @(posedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            tgl_rise <= 1'b0;
        end else begin
            tgl_rise <= !tgl_rise;
        end
    end

    always_ff @(negedge k_clk_in or negedge rst_k_n) begin
        if (!rst_k_n) begin
            tgl_fall <= 1'b0;
        end else begin
            // a copy, not a toggle: the first edge out of reset cannot invert the phase
            tgl_fall <= tgl_rise;
        end
    end

    // high after a true edge, low after a complement edge; free running
    assign echo_phase = tgl_rise ^ tgl_fall;
    assign echo_clock_true_out = echo_phase;
    assign echo_clock_complement_out = !echo_phase;

    // ----------------------------------------------------------------
    // data bus drive
    // ----------------------------------------------------------------
    // the enable spans both beats; overlap with host writes is the host's to avoid
    assign dq_oe_out = rd_active;
    assign dq_out = echo_phase ? q_beat0 : q_beat1;
    assign read_valid_flag_out = rd_active;

endmodule : ddr_sram_port

// *** bench/port_props.sv ***
`include "ddr_sram_consts.svh"

module port_props #(
    parameter bit WIDE_ORG = 1'b1,
    localparam int DW = WIDE_ORG ? `ORG_WIDE_DW : `ORG_NARROW_DW
) (
    // clocks and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic k_clk_in,
    // dll
    input wire logic dll_off_n_in,
    input wire logic dll_locked_out,
    // command
    input wire logic load_select_n_in,
    input wire logic read_not_write_in,
    // read return
    input wire logic [DW-1:0] dq_out,
    input wire logic dq_oe_out,
    input wire logic echo_clock_true_out,
    input wire logic echo_clock_complement_out,
    input wire logic read_valid_flag_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // helpers
    // ----------------
    logic rd;
    logic idle;
    logic wr;
    logic [10:0] on_cnt;
    assign rd = !load_select_n_in && read_not_write_in;
    assign idle = !rd;
    assign wr = !load_select_n_in && !read_not_write_in;
    // saturates so a long enable never wraps into a false early lock
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            on_cnt <= 11'h000;
        end else if (!dll_off_n_in) begin
            on_cnt <= 11'h000;
        end else if (on_cnt != 11'h7FF) begin
            on_cnt <= on_cnt + 11'h001;
        end
    end
    // ----------------
    // link side
    // ----------------
    AST_RD_LAT2: assert property (@(posedge k_clk_in) disable iff (!rstn_in)
        rd && dll_off_n_in && $past(dll_off_n_in, 4) |-> ##3 read_valid_flag_out)
        else $error("read data late");
    AST_RD_LAT1: assert property (@(posedge k_clk_in) disable iff (!rstn_in)
        rd && !dll_off_n_in && !$past(dll_off_n_in, 4) |-> ##2 read_valid_flag_out)
        else $error("bypass read data late");
    AST_ONE_BURST: assert property (@(posedge k_clk_in) disable iff (!rstn_in)
        rd && dll_off_n_in && $past(dll_off_n_in, 4) ##1 idle |-> ##2 dq_oe_out ##1 !dq_oe_out)
        else $error("read burst not one cycle");
    AST_NO_ACCESS: assert property (@(posedge k_clk_in) disable iff (!rstn_in)
        idle && dll_off_n_in && $past(dll_off_n_in, 4) |-> ##3 !read_valid_flag_out)
        else $error("data without a read");
    AST_WR_BUS_FREE: assert property (@(posedge k_clk_in) disable iff (!rstn_in)
        wr && $past(idle) && dll_off_n_in && $past(dll_off_n_in, 4)
        |-> ##2 !dq_oe_out ##1 !dq_oe_out)
        else $error("bus driven during write beats");
    AST_ECHO_WITH_DATA: assert property (@(negedge k_clk_in) disable iff (!rstn_in)
        read_valid_flag_out |-> echo_clock_true_out)
        else $error("echo low in data window");
    // ----------------
    // core side
    // ----------------
    AST_ECHO_PAIR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        echo_clock_complement_out != echo_clock_true_out)
        else $error("echo pair not complementary");
    AST_VALID_ON_ECHO: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $changed(read_valid_flag_out) |-> $rose(echo_clock_true_out))
        else $error("valid off echo edge");
    AST_BEAT_ON_ECHO: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        dq_oe_out && $changed(dq_out) |-> $changed(echo_clock_true_out))
        else $error("read data off echo edge");
    AST_DLL_DROP: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(dll_off_n_in) |-> ##[1:4] !dll_locked_out)
        else $error("lock not dropped");
    AST_LOCK_TIME: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(dll_locked_out) |-> on_cnt >= 11'h3E3 && on_cnt <= 11'h3F2)
        else $error("lock time wrong");
endmodule : port_props

// *** bench/host_ctrl.sv ***
module host_ctrl #(
    parameter int AW = 19,
    parameter int DW = 36
) (
    // link clock
    input wire logic k_clk_in,
    // towards the memory
    output logic sel_n_out,
    output logic rnw_out,
    output logic [AW-1:0] addr_out,
    output logic [DW-1:0] dq_drv_out,
    output logic [DW/9-1:0] mask_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sel_n_out = 1'b1;
        rnw_out = 1'b1;
        addr_out = '0;
        dq_drv_out = '0;
        mask_n_out = '1;
    end
    // changed mid-cycle, taken at the next rising edge only
    task automatic cmd(input logic r, input logic [AW-1:0] a);
        @(negedge k_clk_in);
        sel_n_out = 1'b0;
        rnw_out = r;
        addr_out = a;
    endtask : cmd
    // deselected address and direction wobble so that a stale capture shows
    task automatic idle();
        @(negedge k_clk_in);
        sel_n_out = 1'b1;
        addr_out = ~addr_out;
        rnw_out = ~rnw_out;
    endtask : idle
    // call in the step of the next command slot; two beats, masks with each
    task automatic beats(input logic [DW-1:0] d0, input logic [DW-1:0] d1,
            input logic [DW/9-1:0] m0, input logic [DW/9-1:0] m1);
        dq_drv_out = d0;
        mask_n_out = m0;
        @(posedge k_clk_in);
        #1;
        dq_drv_out = d1;
        mask_n_out = m1;
        // beat two is sampled on this very edge, so release only by non-blocking update
        @(negedge k_clk_in);
        sel_n_out <= 1'b1;
        dq_drv_out <= ~d1;
        mask_n_out <= ~m1;
    endtask : beats
endmodule : host_ctrl

// *** bench/tb_top.sv ***
`include "ddr_sram_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DW = `ORG_WIDE_DW;
    localparam int AW = `ORG_WIDE_AW;
    localparam int NB = DW / `BYTE_LANE_W;
    localparam logic [DW-1:0] D0 = 36'h123456789;
    localparam logic [DW-1:0] D1 = 36'hFEDCBA987;
    localparam logic [DW-1:0] D2 = 36'h0F0F0F0F0;
    localparam logic [DW-1:0] D3 = 36'hA5A5A5A5A;
    localparam logic [DW-1:0] ONES = 36'hFFFFFFFFF;
    localparam logic [DW-1:0] ZERO = 36'h000000000;
    localparam logic [AW-1:0] A1 = 19'h00005;
    localparam logic [AW-1:0] A2 = 19'h7FFFF;
    localparam logic [AW-1:0] A3 = 19'h40000;
    logic ref_clk = 1'b0;
    logic k_clk = 1'b0;
    logic rstn = 1'b0;
    logic dll_off_n = 1'b1;
    logic sel_n;
    logic rnw;
    logic [AW-1:0] addr;
    logic [DW-1:0] host_dq;
    logic [NB-1:0] mask_n;
    logic [DW-1:0] dq_in;
    logic [DW-1:0] dq_out;
    logic dq_oe;
    logic locked;
    logic echo_t;
    logic echo_c;
    logic valid;
    int fail_count = 0;
    int checks_done = 0;

    always #2 ref_clk = ~ref_clk;
    // link clock, unrelated in phase to the core clock
    initial begin
        #1.3;
        forever #62.5 k_clk = ~k_clk;
    end
    assign dq_in = dq_oe ? dq_out : host_dq;

    host_ctrl #(.AW(AW), .DW(DW)) host (.k_clk_in(k_clk), .sel_n_out(sel_n), .rnw_out(rnw),
        .addr_out(addr), .dq_drv_out(host_dq), .mask_n_out(mask_n));
    ddr_sram_port #(.WIDE_ORG(1'b1)) dut (.ref_clk_in(ref_clk), .rstn_in(rstn),
        .k_clk_in(k_clk), .dll_off_n_in(dll_off_n), .dll_locked_out(locked),
        .load_select_n_in(sel_n), .read_not_write_in(rnw), .sync_address_bus_in(addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe), .byte_write_mask_n_in(mask_n),
        .echo_clock_true_out(echo_t), .echo_clock_complement_out(echo_c),
        .read_valid_flag_out(valid));

    task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // one burst: beat one under the true echo high, beat two under it low
    task automatic see(input logic [DW-1:0] d0, input logic [DW-1:0] d1, input bit last);
        @(posedge k_clk);
        #30;
        chk("valid", 1, valid);
        chk("echo", 1, echo_t);
        chk("beat0", d0, dq_out);
        @(negedge k_clk);
        #30;
        chk("bus enable", 1, dq_oe);
        chk("echo_c", 1, echo_c);
        chk("beat1", d1, dq_out);
        if (last) begin
            @(posedge k_clk);
            #30;
            chk("bus released", 0, dq_oe);
        end
    endtask : see
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
            input logic [NB-1:0] m0, input logic [NB-1:0] m1);
        host.cmd(1'b0, a);
        host.idle();
        host.beats(d0, d1, m0, m1);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input int lat, input logic [DW-1:0] d0,
            input logic [DW-1:0] d1);
        host.cmd(1'b1, a);
        host.idle();
        repeat (lat - 1) @(posedge k_clk);
        see(d0, d1, 1'b1);
    endtask : rd
    task automatic t_write_read();
        host.cmd(1'b0, A1);
        host.cmd(1'b1, A1);
        host.beats(D0, D1, 4'h0, 4'h0);
        @(posedge k_clk);
        see(D0, D1, 1'b1);
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_mask();
        host.idle();
        wr(A2, ONES, ONES, 4'h0, 4'h0);
        wr(A2, ZERO, ZERO, 4'hA, 4'h5);
        rd(A2, 2, 36'hFF803FE00, 36'h007FC01FF);
        repeat (4) host.idle();
        rd(A2, 2, 36'hFF803FE00, 36'h007FC01FF);
        $display("test mask done");
    endtask : t_mask
    task automatic t_deselect();
        repeat (6) begin
            host.idle();
            chk("valid while deselected", 0, valid);
        end
        rd(A1, 2, D0, D1);
        $display("test deselect done");
    endtask : t_deselect
    task automatic t_b2b();
        wr(A3, D2, D3, 4'h0, 4'h0);
        host.cmd(1'b1, A1);
        host.cmd(1'b1, A3);
        host.idle();
        see(D0, D1, 1'b0);
        see(D2, D3, 1'b1);
        $display("test back_to_back done");
    endtask : t_b2b
    task automatic t_bypass();
        int n;
        @(negedge ref_clk);
        dll_off_n = 1'b0;
        repeat (4) @(posedge k_clk);
        chk("lock dropped", 0, locked);
        rd(A3, 1, D2, D3);
        // at latency one a read right behind a write must be served from the write buffer
        host.cmd(1'b0, A2);
        host.cmd(1'b1, A2);
        host.beats(D3, D2, 4'h0, 4'h0);
        see(D3, D2, 1'b1);
        @(negedge ref_clk);
        dll_off_n = 1'b1;
        n = 0;
        while (locked !== 1'b1 && n < 1200) begin
            @(negedge ref_clk);
            n++;
        end
        chk("lock time", 1, n > 990 && n < 1010);
        if (n >= 1200) begin
            stop_test();
        end
        repeat (4) @(posedge k_clk);
        rd(A1, 2, D0, D1);
        $display("test bypass done");
    endtask : t_bypass

    initial begin
        repeat (8) @(negedge ref_clk);
        repeat (3) @(posedge k_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (6) @(posedge k_clk);
        t_write_read();
        t_mask();
        t_deselect();
        t_b2b();
        t_bypass();
        stop_test();
    end
endmodule : tb_top

bind ddr_sram_port port_props #(.WIDE_ORG(WIDE_ORG)) props (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .k_clk_in(k_clk_in),
    .dll_off_n_in(dll_off_n_in), .dll_locked_out(dll_locked_out),
    .load_select_n_in(load_select_n_in), .read_not_write_in(read_not_write_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .echo_clock_true_out(echo_clock_true_out),
    .echo_clock_complement_out(echo_clock_complement_out),
    .read_valid_flag_out(read_valid_flag_out));
